/* src/was_pkg.sv */
// Summary of operation
// - Software may set flag while generator disabled
// - Leave shutdown at next input rising edge
// - B/D field bits 5-4: high, low, tristate, inactive
// - A/C field bits 3-2: 11 high, 10 low
// - A/C 01 tristate, 00 inactive after dead-band
// - Shutdown control register bits 1-0 read as zero
package was_pkg;
   localparam logic [3:0]  WAS_OFF_SHDN_CTRL = 4'h0;
   localparam logic [3:0]  WAS_OFF_GEN_CTRL  = 4'h4;
   localparam logic [3:0]  WAS_OFF_IRQ_STAT  = 4'h8;
   localparam logic [3:0]  WAS_OFF_IRQ_MASK  = 4'hc;
   localparam int          WAS_BIT_SHDN      = 7;
   localparam int          WAS_BIT_REN       = 6;
   localparam int          WAS_BD_LSB        = 4;
   localparam int          WAS_AC_LSB        = 2;
   localparam logic [1:0]  WAS_ST_HIGH       = 2'h3;
   localparam logic [1:0]  WAS_ST_LOW        = 2'h2;
   localparam logic [1:0]  WAS_ST_TRI        = 2'h1;
   localparam logic [1:0]  WAS_ST_INACT      = 2'h0;
   localparam logic [1:0]  WAS_BD_RESET      = 2'h1;
   localparam logic [1:0]  WAS_AC_RESET      = 2'h1;
   localparam logic [1:0]  WAS_RESP_OKAY     = 2'h0;
   localparam logic [1:0]  WAS_RESP_SLVERR   = 2'h2;
   localparam int          WAS_DEADBAND_NS   = 50;
   localparam int          WAS_CLK_NS        = 10;
   localparam int          WAS_DEADBAND_CYC  = (WAS_DEADBAND_NS + WAS_CLK_NS - 1) / WAS_CLK_NS;
   localparam int          WAS_IRQ_ENTER     = 0;
   localparam int          WAS_IRQ_RESUME    = 1;
endpackage : was_pkg

/* src/was_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module was_sync #(
   parameter int W = 1
) (
   input  wire logic         sys_clk,
   input  wire logic         reset_n,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   logic [W-1:0] meta_ff;

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         meta_ff <= '0;
         q       <= '0;
      end else begin
         meta_ff <= d;
         q       <= meta_ff;
      end
   end
endmodule : was_sync
`default_nettype wire

/* src/was_top.sv */
// Local design decisions: the address map and register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
module was_top
   import was_pkg::*;
#(
   parameter int DEADBAND_CYC = WAS_DEADBAND_CYC
) (
   input  wire logic        sys_clk,
   input  wire logic        reset_n,
   input  wire logic [3:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [3:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   input  wire logic        wave_in,
   input  wire logic        shdn_event_in,
   input  wire logic [3:0]  wave_drive,
   input  wire logic [3:0]  inact_level,
   output logic [3:0]       pin_out_ff,
   output logic [3:0]       pin_oe_ff,
   output logic             irq_ff
);
   // Pin order: [0]=A [1]=B [2]=C [3]=D
   logic       wave_s, event_s, wave_d_ff;
   logic       shdn_ff, ren_ff, gen_en_ff, hold_ff;
   logic [1:0] bd_state_ff, ac_state_ff, irq_stat_ff, irq_mask_ff;
   logic [3:0] aw_addr_ff, ar_addr_ff;
   logic [31:0] w_data_ff;
   logic [3:0] w_strb_ff;
   logic       aw_got_ff, w_got_ff;
   logic [7:0] db_cnt_ff;
   logic       rise, wr_fire, wr_ok, sw_clr_shdn, sw_set_shdn, nxt_shdn, enter, resume;

   was_sync #(.W(2)) u_sync (
      .sys_clk (sys_clk),
      .reset_n (reset_n),
      .d       ({wave_in, shdn_event_in}),
      .q       ({wave_s, event_s})
   );

   function automatic logic [31:0] shdn_word(input logic s, input logic r,
                                             input logic [1:0] bd, input logic [1:0] ac);
      shdn_word = {24'h0, s, r, bd, ac, 2'h0};
   endfunction : shdn_word

   // AXI write path: address and data taken in either order
   assign wr_fire = aw_got_ff && w_got_ff && !s_axi_bvalid;
   assign wr_ok   = (aw_addr_ff == WAS_OFF_SHDN_CTRL) || (aw_addr_ff == WAS_OFF_GEN_CTRL) ||
                    (aw_addr_ff == WAS_OFF_IRQ_STAT) || (aw_addr_ff == WAS_OFF_IRQ_MASK);

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         aw_got_ff     <= 1'b0;
         w_got_ff      <= 1'b0;
         aw_addr_ff    <= 4'h0;
         w_data_ff     <= 32'h0;
         w_strb_ff     <= 4'h0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= WAS_RESP_OKAY;
      end else begin
         s_axi_awready <= !aw_got_ff && !s_axi_awready && s_axi_awvalid;
         s_axi_wready  <= !w_got_ff && !s_axi_wready && s_axi_wvalid;
         if (s_axi_awvalid && s_axi_awready) begin
            aw_got_ff  <= 1'b1;
            aw_addr_ff <= {s_axi_awaddr[3:2], 2'h0};
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_got_ff  <= 1'b1;
            w_data_ff <= s_axi_wdata;
            w_strb_ff <= s_axi_wstrb;
         end
         if (wr_fire) begin
            aw_got_ff    <= 1'b0;
            w_got_ff     <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_ok ? WAS_RESP_OKAY : WAS_RESP_SLVERR;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // Only byte lane 0 holds register bits
   logic wr_lane0;
   assign wr_lane0    = wr_fire && w_strb_ff[0];
   assign sw_set_shdn = wr_lane0 && aw_addr_ff == WAS_OFF_SHDN_CTRL && w_data_ff[WAS_BIT_SHDN]
                        && !gen_en_ff;
   assign sw_clr_shdn = wr_lane0 && aw_addr_ff == WAS_OFF_SHDN_CTRL && !w_data_ff[WAS_BIT_SHDN];

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         ren_ff      <= 1'b0;
         bd_state_ff <= WAS_BD_RESET;
         ac_state_ff <= WAS_AC_RESET;
         gen_en_ff   <= 1'b0;
      end else if (wr_lane0) begin
         if (aw_addr_ff == WAS_OFF_SHDN_CTRL) begin
            ren_ff      <= w_data_ff[WAS_BIT_REN];
            bd_state_ff <= w_data_ff[WAS_BD_LSB +: 2];
            ac_state_ff <= w_data_ff[WAS_AC_LSB +: 2];
         end else if (aw_addr_ff == WAS_OFF_GEN_CTRL) begin
            gen_en_ff <= w_data_ff[0];
         end
      end
   end

   // Shutdown flag: a live event wins over any clear
   always_comb begin
      nxt_shdn = shdn_ff;
      if (sw_clr_shdn) nxt_shdn = 1'b0;
      if (ren_ff && !event_s) nxt_shdn = 1'b0;
      if (sw_set_shdn) nxt_shdn = 1'b1;
      if (event_s) nxt_shdn = 1'b1;
   end

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         shdn_ff   <= 1'b0;
         hold_ff   <= 1'b0;
         wave_d_ff <= 1'b0;
      end else begin
         shdn_ff   <= nxt_shdn;
         wave_d_ff <= wave_s;
         if (nxt_shdn) hold_ff <= 1'b1;
         else if (rise) hold_ff <= 1'b0;
      end
   end

   assign rise   = wave_s && !wave_d_ff;
   assign enter  = nxt_shdn && !hold_ff;
   assign resume = hold_ff && !nxt_shdn && !shdn_ff && rise;

   // Dead-band before inactive level is applied
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         db_cnt_ff <= 8'h0;
      end else if (!hold_ff) begin
         db_cnt_ff <= 8'h0;
      end else if (db_cnt_ff < 8'(DEADBAND_CYC)) begin
         db_cnt_ff <= db_cnt_ff + 8'h1;
      end
   end

   // Per pin drive during shutdown
   function automatic logic [1:0] pin_drive(input logic [1:0] st, input logic inact,
                                            input logic db_done);
      case (st)
         WAS_ST_HIGH: pin_drive = 2'b11;
         WAS_ST_LOW:  pin_drive = 2'b01;
         WAS_ST_TRI:  pin_drive = 2'b00;
         default:     pin_drive = {inact && db_done, 1'b1};
      endcase
   endfunction : pin_drive

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         pin_out_ff <= 4'h0;
         pin_oe_ff  <= 4'h0;
      end else if (hold_ff) begin
         for (int i = 0; i < 4; i++) begin
            logic [1:0] d;
            d = pin_drive(i[0] ? bd_state_ff : ac_state_ff, inact_level[i],
                          db_cnt_ff >= 8'(DEADBAND_CYC));
            pin_out_ff[i] <= d[1];
            pin_oe_ff[i]  <= d[0];
         end
      end else begin
         pin_out_ff <= gen_en_ff ? wave_drive : inact_level;
         pin_oe_ff  <= {4{gen_en_ff}};
      end
   end

   // Sticky events, write one to clear, set wins
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         irq_stat_ff <= 2'h0;
         irq_mask_ff <= 2'h0;
         irq_ff      <= 1'b0;
      end else begin
         if (wr_lane0 && aw_addr_ff == WAS_OFF_IRQ_STAT) irq_stat_ff <= irq_stat_ff & ~w_data_ff[1:0]
            | {resume, enter};
         else irq_stat_ff <= irq_stat_ff | {resume, enter};
         if (wr_lane0 && aw_addr_ff == WAS_OFF_IRQ_MASK) irq_mask_ff <= w_data_ff[1:0];
         irq_ff <= |(irq_stat_ff & irq_mask_ff);
      end
   end

   // AXI read path
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0;
         s_axi_rresp   <= WAS_RESP_OKAY;
         ar_addr_ff    <= 4'h0;
      end else begin
         s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= WAS_RESP_OKAY;
            if (s_axi_araddr[3:2] == WAS_OFF_SHDN_CTRL[3:2]) begin
               s_axi_rdata <= shdn_word(shdn_ff, ren_ff, bd_state_ff, ac_state_ff);
            end else if (s_axi_araddr[3:2] == WAS_OFF_GEN_CTRL[3:2]) begin
               s_axi_rdata <= {31'h0, gen_en_ff};
            end else if (s_axi_araddr[3:2] == WAS_OFF_IRQ_STAT[3:2]) begin
               s_axi_rdata <= {30'h0, irq_stat_ff};
            end else begin
               s_axi_rdata <= {30'h0, irq_mask_ff};
            end
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // Flag and hold state
   a_event_sets_flag: assert property (@(posedge sys_clk) disable iff (!reset_n)
      event_s |=> shdn_ff)
      else $error("event did not set flag");
   a_sw_set_flag: assert property (@(posedge sys_clk) disable iff (!reset_n)
      sw_set_shdn |=> shdn_ff && hold_ff)
      else $error("software set ignored");
   a_hold_till_rise: assert property (@(posedge sys_clk) disable iff (!reset_n)
      hold_ff && !rise |=> hold_ff)
      else $error("left shutdown without edge");
   a_resume_at_rise: assert property (@(posedge sys_clk) disable iff (!reset_n)
      hold_ff && rise && !nxt_shdn |=> !hold_ff)
      else $error("edge did not end shutdown");
   a_normal_drive: assert property (@(posedge sys_clk) disable iff (!reset_n)
      !hold_ff && gen_en_ff |=> pin_out_ff == $past(wave_drive) && pin_oe_ff == 4'hf)
      else $error("normal drive wrong");
   a_ren_written: assert property (@(posedge sys_clk) disable iff (!reset_n)
      wr_lane0 && aw_addr_ff == WAS_OFF_SHDN_CTRL |=> ren_ff == $past(w_data_ff[WAS_BIT_REN]))
      else $error("restart enable not stored");
   a_auto_clear: assert property (@(posedge sys_clk) disable iff (!reset_n)
      shdn_ff && ren_ff && !event_s && !sw_set_shdn |=> !shdn_ff)
      else $error("no auto clear");
   a_flag_sticky: assert property (@(posedge sys_clk) disable iff (!reset_n)
      shdn_ff && !ren_ff && !sw_clr_shdn |=> shdn_ff)
      else $error("flag cleared itself");

   // Pin drive while held, one cycle after the state is seen
   a_bd_high: assert property (@(posedge sys_clk) disable iff (!reset_n)
      hold_ff && bd_state_ff == WAS_ST_HIGH
      |=> pin_out_ff[1] && pin_oe_ff[1] && pin_out_ff[3] && pin_oe_ff[3])
      else $error("bd high wrong");
   a_bd_tri: assert property (@(posedge sys_clk) disable iff (!reset_n)
      hold_ff && bd_state_ff == WAS_ST_TRI |=> !pin_oe_ff[1] && !pin_oe_ff[3])
      else $error("bd tri wrong");
   a_bd_inactive: assert property (@(posedge sys_clk) disable iff (!reset_n)
      hold_ff && bd_state_ff == WAS_ST_INACT && db_cnt_ff >= 8'(DEADBAND_CYC)
      |=> pin_oe_ff[1] && pin_out_ff[1] == $past(inact_level[1])
      && pin_oe_ff[3] && pin_out_ff[3] == $past(inact_level[3]))
      else $error("bd inactive wrong");
   a_ac_high: assert property (@(posedge sys_clk) disable iff (!reset_n)
      hold_ff && ac_state_ff == WAS_ST_HIGH
      |=> pin_out_ff[0] && pin_oe_ff[0] && pin_out_ff[2] && pin_oe_ff[2])
      else $error("ac high wrong");
   a_ac_low: assert property (@(posedge sys_clk) disable iff (!reset_n)
      hold_ff && ac_state_ff == WAS_ST_LOW
      |=> !pin_out_ff[0] && pin_oe_ff[0] && !pin_out_ff[2] && pin_oe_ff[2])
      else $error("ac low wrong");
   a_ac_tri: assert property (@(posedge sys_clk) disable iff (!reset_n)
      hold_ff && ac_state_ff == WAS_ST_TRI |=> !pin_oe_ff[0] && !pin_oe_ff[2])
      else $error("ac tri wrong");
   a_ac_inactive: assert property (@(posedge sys_clk) disable iff (!reset_n)
      hold_ff && ac_state_ff == WAS_ST_INACT && db_cnt_ff >= 8'(DEADBAND_CYC)
      |=> pin_oe_ff[0] && pin_out_ff[0] == $past(inact_level[0])
      && pin_oe_ff[2] && pin_out_ff[2] == $past(inact_level[2]))
      else $error("ac inactive wrong");
   a_bd_low: assert property (@(posedge sys_clk) disable iff (!reset_n)
      hold_ff && bd_state_ff == WAS_ST_LOW
      |=> !pin_out_ff[1] && pin_oe_ff[1] && !pin_out_ff[3] && pin_oe_ff[3])
      else $error("bd low wrong");

   // Register bus answers and read-back
   a_low_bits_zero: assert property (@(posedge sys_clk) disable iff (!reset_n)
      $rose(s_axi_rvalid) && $past(s_axi_araddr[3:2]) == WAS_OFF_SHDN_CTRL[3:2]
      |-> s_axi_rdata[1:0] == 2'h0)
      else $error("low bits not zero");
   a_wr_answer: assert property (@(posedge sys_clk) disable iff (!reset_n)
      wr_fire |=> s_axi_bvalid)
      else $error("write not answered");
   a_rd_answer: assert property (@(posedge sys_clk) disable iff (!reset_n)
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read not answered");

   // Interrupt level follows masked status one cycle later
   a_irq_raised: assert property (@(posedge sys_clk) disable iff (!reset_n)
      |(irq_stat_ff & irq_mask_ff) |=> irq_ff)
      else $error("interrupt not raised");
   a_irq_quiet: assert property (@(posedge sys_clk) disable iff (!reset_n)
      !(|(irq_stat_ff & irq_mask_ff)) |=> !irq_ff)
      else $error("interrupt without cause");
endmodule : was_top
`default_nettype wire

/* sim/was_load.sv */
`timescale 1ns/1ps
`default_nettype none
module was_load (
   input  wire logic [3:0] pin_out,
   input  wire logic [3:0] pin_oe,
   input  wire logic       fault_req,
   output logic      [3:0] pin_lvl,
   output logic            fault_out
);
   logic [3:0] last = 4'h0;
   // Released pin floats; show the inverse of its last driven level
   always @(pin_out or pin_oe) begin
      last = (pin_out & pin_oe) | (last & ~pin_oe);
      pin_lvl = (pin_out & pin_oe) | (~last & ~pin_oe);
   end
   // Stage reports over-current as a level while it lasts
   assign fault_out = fault_req;
endmodule : was_load
`default_nettype wire

/* sim/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb
   import was_pkg::*;
;
   logic        sys_clk, reset_n, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
   logic        s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic        s_axi_rvalid, s_axi_rready, wave_in, shdn_event_in, irq_ff, fault_req;
   logic [3:0]  s_axi_awaddr, s_axi_araddr, s_axi_wstrb, wave_drive, inact_level;
   logic [3:0]  pin_out_ff, pin_oe_ff, pin_lvl;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic [31:0] s_axi_wdata, s_axi_rdata, rng, exp_q[$];
   int          mismatches, checked;

   was_top #(.DEADBAND_CYC(2)) was_top_i (.*);
   was_load was_load_i (.pin_out(pin_out_ff), .pin_oe(pin_oe_ff), .fault_req(fault_req),
                        .pin_lvl(pin_lvl), .fault_out(shdn_event_in));

   initial begin
      sys_clk = 1'h0;
      forever #5 sys_clk = ~sys_clk;
   end

   function automatic logic [31:0] xs(input logic [31:0] x);
      x ^= x << 13;
      x ^= x >> 17;
      x ^= x << 5;
      return x;
   endfunction : xs

   function automatic logic [31:0] ctl(input logic f, r, input logic [1:0] bd, ac);
      return {24'h0, f, r, bd, ac, 2'h0};
   endfunction : ctl

   function automatic logic [31:0] pins(input logic [1:0] bd, ac, input logic [3:0] lv);
      logic [3:0] oe, o;
      logic [1:0] c;
      for (int i = 0; i < 4; i++) begin
         c = i[0] ? bd : ac;
         oe[i] = (c != WAS_ST_TRI);
         o[i] = (c == WAS_ST_HIGH) | ((c == WAS_ST_INACT) & lv[i]);
      end
      return {24'h0, oe, o & oe};
   endfunction : pins

   task automatic chk(input logic [31:0] got, exp);
      checked++;
      if (got !== exp) begin
         mismatches++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task automatic w(input int n);
      repeat (n) @(posedge sys_clk);
   endtask : w

   task automatic pc(input logic [31:0] e);
      chk({24'h0, pin_oe_ff, pin_lvl & pin_oe_ff}, e);
   endtask : pc

   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      int n;
      s_axi_awaddr  <= a;
      s_axi_wdata   <= d;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid  <= 1'h1;
      s_axi_bready  <= 1'h1;
      n = 0;
      do begin
         @(posedge sys_clk);
         n++;
         if (s_axi_awready) s_axi_awvalid <= 1'h0;
         if (s_axi_wready) s_axi_wvalid <= 1'h0;
      end while (s_axi_bvalid !== 1'h1 && n < 50);
      chk({31'h0, s_axi_bvalid}, 32'h1);
      s_axi_bready <= 1'h0;
      chk({30'h0, s_axi_bresp}, {30'h0, WAS_RESP_OKAY});
      @(posedge sys_clk);
   endtask : wr

   task automatic rd(input logic [3:0] a, input logic [31:0] e);
      int n;
      exp_q.push_back(e);
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready  <= 1'h1;
      n = 0;
      do begin
         @(posedge sys_clk);
         n++;
         if (s_axi_arready) s_axi_arvalid <= 1'h0;
      end while (s_axi_rvalid !== 1'h1 && n < 50);
      s_axi_rready <= 1'h0;
      @(posedge sys_clk);
   endtask : rd

   // Read data is judged against the oldest noted expectation
   always @(posedge sys_clk)
      if (s_axi_rvalid === 1'h1 && s_axi_rready === 1'h1 && exp_q.size() > 0)
         chk(s_axi_rdata, exp_q.pop_front());

   task automatic test_done();
      // A read that never answered leaves its note behind
      mismatches += exp_q.size();
      $display("Counts: mismatches=%0d checked=%0d", mismatches, checked);
      if (mismatches == 0 && checked > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : test_done

   initial begin
      repeat (5000) @(posedge sys_clk);
      mismatches++;
      test_done();
   end

   initial begin
      reset_n = 1'h0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, wave_in, fault_req, wave_drive} = '0;
      s_axi_wstrb = 4'hf;
      mismatches = 0;
      checked = 0;
      rng = xs(32'd95000);
      inact_level = rng[3:0];
      w(8);
      reset_n <= 1'h1;
      w(1);
      rd(WAS_OFF_SHDN_CTRL, ctl(1'h0, 1'h0, WAS_BD_RESET, WAS_AC_RESET));
      // Every code on both pairs, each pair given a different code
      for (int c = 0; c < 4; c++) begin
         wr(WAS_OFF_SHDN_CTRL, ctl(1'h1, 1'h0, c[1:0], ~c[1:0]) | 32'h3);
         rd(WAS_OFF_SHDN_CTRL, ctl(1'h1, 1'h0, c[1:0], ~c[1:0]));
         w(10);
         pc(pins(c[1:0], ~c[1:0], inact_level));
      end
      wr(WAS_OFF_SHDN_CTRL, ctl(1'h0, 1'h0, 2'h3, 2'h3));
      w(10);
      pc(pins(2'h3, 2'h3, inact_level));
      wr(WAS_OFF_GEN_CTRL, 32'h1);
      wr(WAS_OFF_SHDN_CTRL, ctl(1'h1, 1'h0, 2'h3, 2'h3));
      rd(WAS_OFF_SHDN_CTRL, ctl(1'h0, 1'h0, 2'h3, 2'h3));
      rng = xs(rng);
      wave_drive <= rng[3:0];
      wave_in <= 1'h1;
      w(10);
      pc({24'h0, 4'hf, rng[3:0]});
      wr(WAS_OFF_IRQ_STAT, 32'h3);
      wr(WAS_OFF_IRQ_MASK, 32'h1);
      rd(WAS_OFF_IRQ_STAT, 32'h0);
      fault_req <= 1'h1;
      w(8);
      rd(WAS_OFF_SHDN_CTRL, ctl(1'h1, 1'h0, 2'h3, 2'h3));
      pc(pins(2'h3, 2'h3, inact_level));
      rd(WAS_OFF_IRQ_STAT, 32'h1);
      chk({31'h0, irq_ff}, 32'h1);
      fault_req <= 1'h0;
      w(8);
      rd(WAS_OFF_SHDN_CTRL, ctl(1'h1, 1'h0, 2'h3, 2'h3));
      wr(WAS_OFF_IRQ_MASK, 32'h0);
      w(2);
      chk({31'h0, irq_ff}, 32'h0);
      wr(WAS_OFF_IRQ_STAT, 32'h1);
      rd(WAS_OFF_IRQ_STAT, 32'h0);
      wr(WAS_OFF_SHDN_CTRL, ctl(1'h0, 1'h1, 2'h3, 2'h3));
      fault_req <= 1'h1;
      w(8);
      rd(WAS_OFF_SHDN_CTRL, ctl(1'h1, 1'h1, 2'h3, 2'h3));
      fault_req <= 1'h0;
      w(8);
      rd(WAS_OFF_SHDN_CTRL, ctl(1'h0, 1'h1, 2'h3, 2'h3));
      w(4);
      test_done();
   end
endmodule : tb
`default_nettype wire
